// file: output_signal_selector.v
// output terminal source selector: one assignment code per terminal picks the status
// that drives it; codes are written over a classic 32-bit wishbone slave
// assumes all status inputs come from logic on the same clock, events as one-cycle pulses
//
// Overview of operation
// - host picks terminal source by code; zero unused
// - codes 1 to 127 echo input state
// - code 128 holds terminal off
// - 129 alarm true, 130 alarm inverted
// - 131 system prepared, 132 driver ready
// - 134 shows motor moving
// - 135 shows any information condition present
// - 136 shows internal processing
// - 138 positioning done, never in cyclic mode
// - 140 shows torque at upper limit
// - 141 speed reached, never in cyclic mode
// - 142 motor excited, 143 current cutback
// - 144 shows home reached or preset done
// - 145 shows coordinates established
// - 149 shows another preset required
// - 150 mechanical home, 151 factory home set
// - 152 toggles on each wrap overflow
// - 153 forward, 154 reverse soft limit
// - 155 pulses per revolution from preset
// - 156 wrap home, only wrap enabled
// - 157 pulses per 7.2 degree step
// - 160 to 167 select area window flags
`timescale 1ns/100ps
`include "output_selector_consts.vh"

module output_signal_selector (
    input wire clock,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`ADDR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [127:0] input_state,
    input wire alarm,
    input wire system_prepared,
    input wire drive_ready,
    input wire motor_moving,
    input wire present_a,
    input wire internal_processing,
    input wire positioning_done,
    input wire cyclic_sync_position_mode,
    input wire torque_at_limit,
    input wire speed_reached,
    input wire motor_excited,
    input wire current_cutback,
    input wire home_reached,
    input wire coords_established,
    input wire preset_required,
    input wire mech_home_set,
    input wire factory_home_set,
    input wire wrap_exceeded,
    input wire fwd_soft_limit,
    input wire rev_soft_limit,
    input wire rev_pulse,
    input wire wrap_home_flag,
    input wire wrap_enable,
    input wire step_angle_pulse,
    input wire [7:0] window_flag,
    output reg [`NUM_TERMINALS-1:0] term_out
);

    localparam ST_CLEAR = 3'b001;
    localparam ST_FIRST = 3'b010;
    localparam ST_RUN = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [`TERM_IDX_W-1:0] clear_idx;
    reg [`TERM_IDX_W-1:0] scan_idx;
    reg [`TERM_IDX_W-1:0] scan_idx_d;
    reg scan_valid;
    reg released;
    reg wrap_overflow_toggle;
    reg [1:0] pulse_acc;
    reg [1:0] pulse_round;
    reg [`NUM_TERMINALS-1:0] level_shadow;
    reg hold_all_off;
    reg bus_busy;

    wire [`CODE_W-1:0] scan_code;
    wire [`CODE_W-1:0] bus_code;
    wire round_end;
    wire bus_start;
    wire bus_finish;
    wire ack_commit;
    wire code_write;
    wire table_we;
    wire [`TERM_IDX_W-1:0] table_widx;
    wire [`CODE_W-1:0] table_wcode;
    wire [1:0] pulse_events;
    reg [255:0] source_vec;
    reg selected_level;
    reg [31:0] read_word;

    // code table window covers one aligned word per terminal
    function is_code_addr;
        input [`ADDR_W-1:0] adr;
        begin
            is_code_addr = (adr >= `ADDR_CODE_BASE) && (adr <= `ADDR_CODE_LAST)
                && (adr[1:0] == 2'b00);
        end
    endfunction

    function [`TERM_IDX_W-1:0] code_index;
        input [`ADDR_W-1:0] adr;
        begin
            code_index = adr[`TERM_IDX_W+1:2];
        end
    endfunction

    // a request is live only while both cycle and strobe stand
    function bus_request;
        input cyc;
        input stb;
        begin
            bus_request = cyc && stb;
        end
    endfunction

    // writes touch byte 0 only; a write without its enable is acked and dropped
    function byte0_write;
        input we;
        input [3:0] sel;
        begin
            byte0_write = we && sel[0];
        end
    endfunction

    assign round_end = scan_valid && (scan_idx_d == `LAST_TERMINAL);
    assign bus_start = bus_request(wb_cyc_i, wb_stb_i) && !bus_busy && !wb_ack_o
        && (state != ST_CLEAR);
    assign bus_finish = bus_request(wb_cyc_i, wb_stb_i) && bus_busy && !wb_ack_o;
    // writes commit at the edge where the master samples ack, so a request
    // withdrawn before that edge leaves no trace in the table or control
    assign ack_commit = wb_ack_o && bus_request(wb_cyc_i, wb_stb_i)
        && byte0_write(wb_we_i, wb_sel_i);
    assign code_write = ack_commit && is_code_addr(wb_adr_i);
    // clearing after reset owns the write port; bus access waits for it
    assign table_we = (state == ST_CLEAR) || code_write;
    assign table_widx = (state == ST_CLEAR) ? clear_idx : code_index(wb_adr_i);
    assign table_wcode = (state == ST_CLEAR) ? `CODE_UNUSED : wb_dat_i[`CODE_W-1:0];
    assign pulse_events = {step_angle_pulse, rev_pulse};

    code_table u_code_table (
        .clock(clock),
        .rst_n(rst_n),
        .write_en(table_we),
        .write_idx(table_widx),
        .write_code(table_wcode),
        .scan_idx(scan_idx),
        .scan_code(scan_code),
        .bus_idx(code_index(wb_adr_i)),
        .bus_code(bus_code)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_CLEAR: begin
                if (clear_idx == `LAST_TERMINAL) begin
                    next_state = ST_FIRST;
                end
            end
            ST_FIRST: begin
                if (round_end) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_CLEAR;
            end
        endcase
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            state <= ST_CLEAR;
            clear_idx <= {`TERM_IDX_W{1'b0}};
            released <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_CLEAR) begin
                clear_idx <= clear_idx + 1'b1;
            end
            // terminals stay low until every stored code has been applied once
            if ((state == ST_FIRST) && round_end) begin
                released <= 1'b1;
            end
        end
    end

    // sequential scan trades a 16-cycle refresh for a single-ported decode
    always @(posedge clock) begin
        if (!rst_n) begin
            scan_idx <= {`TERM_IDX_W{1'b0}};
            scan_idx_d <= {`TERM_IDX_W{1'b0}};
            scan_valid <= 1'b0;
        end else begin
            if (state != ST_CLEAR) begin
                scan_idx <= scan_idx + 1'b1;
            end
            scan_idx_d <= scan_idx;
            scan_valid <= (state != ST_CLEAR);
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            wrap_overflow_toggle <= 1'b0;
        end else if (wrap_exceeded) begin
            wrap_overflow_toggle <= ~wrap_overflow_toggle;
        end
    end

    // pulses are held for one full scan round so no terminal can miss them;
    // a pulse in the closing cycle lands in both rounds rather than being lost
    always @(posedge clock) begin
        if (!rst_n) begin
            pulse_acc <= 2'b00;
            pulse_round <= 2'b00;
        end else begin
            pulse_acc <= (round_end ? 2'b00 : pulse_acc) | pulse_events;
            if (round_end) begin
                pulse_round <= pulse_acc | pulse_events;
            end
        end
    end

    // unlisted codes fall through to the zero fill and read as off;
    // the cyclic mode gate sits here so the status inputs stay raw
    // limitation: a code change shows only when its terminal comes round
    always @* begin
        source_vec = 256'h0;
        source_vec[127:1] = input_state[127:1];
        source_vec[`CODE_UNUSED] = 1'b0;
        source_vec[`CODE_CONST_OFF] = 1'b0;
        source_vec[`CODE_ALARM_ACTIVE_HIGH] = alarm;
        source_vec[`CODE_ALARM_ACTIVE_LOW] = ~alarm;
        source_vec[`CODE_SYSTEM_PREPARED] = system_prepared;
        source_vec[`CODE_DRIVE_READY] = drive_ready;
        source_vec[`CODE_MOTOR_MOVING] = motor_moving;
        source_vec[`CODE_PRESENT_A] = present_a;
        source_vec[`CODE_INTERNAL_PROCESSING] = internal_processing;
        source_vec[`CODE_POSITIONING_DONE] = positioning_done
            & ~cyclic_sync_position_mode;
        source_vec[`CODE_TORQUE_AT_LIMIT] = torque_at_limit;
        source_vec[`CODE_SPEED_REACHED] = speed_reached & ~cyclic_sync_position_mode;
        source_vec[`CODE_MOTOR_EXCITED] = motor_excited;
        source_vec[`CODE_CURRENT_CUTBACK] = current_cutback;
        source_vec[`CODE_HOME_REACHED] = home_reached;
        source_vec[`CODE_COORDS_ESTABLISHED] = coords_established;
        source_vec[`CODE_PRESET_REQUIRED] = preset_required;
        source_vec[`CODE_MECH_HOME_SET] = mech_home_set;
        source_vec[`CODE_FACTORY_HOME_SET] = factory_home_set;
        source_vec[`CODE_WRAP_OVERFLOW_TOGGLE] = wrap_overflow_toggle;
        source_vec[`CODE_FWD_SOFT_LIMIT] = fwd_soft_limit;
        source_vec[`CODE_REV_SOFT_LIMIT] = rev_soft_limit;
        source_vec[`CODE_REV_PULSE] = pulse_round[0];
        source_vec[`CODE_WRAP_HOME_FLAG] = wrap_home_flag & wrap_enable;
        source_vec[`CODE_STEP_ANGLE_PULSE] = pulse_round[1];
        source_vec[`CODE_WINDOW_LAST:`CODE_WINDOW_FIRST] = window_flag;
        selected_level = source_vec[scan_code];
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            level_shadow <= {`NUM_TERMINALS{1'b0}};
        end else if (scan_valid) begin
            level_shadow[scan_idx_d] <= selected_level;
        end
    end

    // every terminal comes straight from this register
    always @(posedge clock) begin
        if (!rst_n) begin
            term_out <= {`NUM_TERMINALS{1'b0}};
        end else if (released && !hold_all_off) begin
            term_out <= level_shadow;
        end else begin
            term_out <= {`NUM_TERMINALS{1'b0}};
        end
    end

    always @* begin
        read_word = 32'h0;
        if (is_code_addr(wb_adr_i)) begin
            read_word[`CODE_W-1:0] = bus_code;
        end else if (wb_adr_i == `ADDR_STATUS) begin
            read_word[`NUM_TERMINALS-1:`STATUS_LEVELS_LSB] = term_out;
            read_word[`STATUS_RELEASED_BIT] = released;
            read_word[`STATUS_TOGGLE_BIT] = wrap_overflow_toggle;
        end else if (wb_adr_i == `ADDR_CONTROL) begin
            read_word[`CONTROL_HOLD_OFF_BIT] = hold_all_off;
        end
    end

    // two-step answer: the code table read port needs one cycle
    always @(posedge clock) begin
        if (!rst_n) begin
            bus_busy <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            hold_all_off <= `CONTROL_RESET;
        end else begin
            if (wb_ack_o) begin
                wb_ack_o <= 1'b0;
                bus_busy <= 1'b0;
                if (ack_commit && (wb_adr_i == `ADDR_CONTROL)) begin
                    hold_all_off <= wb_dat_i[`CONTROL_HOLD_OFF_BIT];
                end
            end else if (bus_start) begin
                bus_busy <= 1'b1;
            end else if (bus_finish) begin
                wb_ack_o <= 1'b1;
                wb_dat_o <= wb_we_i ? 32'h0 : read_word;
            end else if (!bus_request(wb_cyc_i, wb_stb_i)) begin
                bus_busy <= 1'b0;
            end
        end
    end

endmodule

// file: output_selector_consts.vh
// constants for the output terminal source selector
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef OUTPUT_SELECTOR_CONSTS_VH
`define OUTPUT_SELECTOR_CONSTS_VH

`define NUM_TERMINALS 16
`define TERM_IDX_W 4
`define CODE_W 8
`define LAST_TERMINAL 4'hF

`define ADDR_W 8
`define ADDR_CODE_BASE 8'h00
`define ADDR_CODE_LAST 8'h3C
`define ADDR_STATUS 8'h40
`define ADDR_CONTROL 8'h44

`define STATUS_LEVELS_LSB 0
`define STATUS_RELEASED_BIT 16
`define STATUS_TOGGLE_BIT 17
`define CONTROL_HOLD_OFF_BIT 0
`define CONTROL_RESET 1'h0

`define CODE_UNUSED 8'h00
`define CODE_ECHO_LAST 8'h7F
`define CODE_CONST_OFF 8'h80
`define CODE_ALARM_ACTIVE_HIGH 8'h81
`define CODE_ALARM_ACTIVE_LOW 8'h82
`define CODE_SYSTEM_PREPARED 8'h83
`define CODE_DRIVE_READY 8'h84
`define CODE_MOTOR_MOVING 8'h86
`define CODE_PRESENT_A 8'h87
`define CODE_INTERNAL_PROCESSING 8'h88
`define CODE_POSITIONING_DONE 8'h8A
`define CODE_TORQUE_AT_LIMIT 8'h8C
`define CODE_SPEED_REACHED 8'h8D
`define CODE_MOTOR_EXCITED 8'h8E
`define CODE_CURRENT_CUTBACK 8'h8F
`define CODE_HOME_REACHED 8'h90
`define CODE_COORDS_ESTABLISHED 8'h91
`define CODE_PRESET_REQUIRED 8'h95
`define CODE_MECH_HOME_SET 8'h96
`define CODE_FACTORY_HOME_SET 8'h97
`define CODE_WRAP_OVERFLOW_TOGGLE 8'h98
`define CODE_FWD_SOFT_LIMIT 8'h99
`define CODE_REV_SOFT_LIMIT 8'h9A
`define CODE_REV_PULSE 8'h9B
`define CODE_WRAP_HOME_FLAG 8'h9C
`define CODE_STEP_ANGLE_PULSE 8'h9D
`define CODE_WINDOW_FIRST 8'hA0
`define CODE_WINDOW_LAST 8'hA7

`endif

// file: code_table.v
// small memory holding one assignment code per output terminal
// one write port, two registered read ports, all on one clock
`timescale 1ns/100ps
`include "output_selector_consts.vh"

module code_table (
    input wire clock,
    input wire rst_n,
    input wire write_en,
    input wire [`TERM_IDX_W-1:0] write_idx,
    input wire [`CODE_W-1:0] write_code,
    input wire [`TERM_IDX_W-1:0] scan_idx,
    output reg [`CODE_W-1:0] scan_code,
    input wire [`TERM_IDX_W-1:0] bus_idx,
    output reg [`CODE_W-1:0] bus_code
);

    reg [`CODE_W-1:0] mem [0:`NUM_TERMINALS-1];

    // array itself is not reset; the owner clears it after reset
    always @(posedge clock) begin
        if (write_en) begin
            mem[write_idx] <= write_code;
        end
    end

    // read of an entry written at the same edge returns the old code
    always @(posedge clock) begin
        if (!rst_n) begin
            scan_code <= `CODE_UNUSED;
            bus_code <= `CODE_UNUSED;
        end else begin
            scan_code <= mem[scan_idx];
            bus_code <= mem[bus_idx];
        end
    end

endmodule

// file: output_signal_selector_pad_none.v
`timescale 1ns/100ps
// holds no logic: the selector and its code table carry the whole block
// assumes nothing of its surroundings

// file: output_selector_checker.sv
// checker: bus handshake, reset and hold-off relations of the selector
// assumes it is bound to the selector top, one clock
`timescale 1ns/100ps
module output_selector_checker (
    input wire clock,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [15:0] term_out
);
    reg hold;
    wire rd = wb_ack_o && !wb_we_i;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // mirror of hold-off, updated at the same edge; terminals clear one edge later, hence the two-edge look back below
    always @(posedge clock) begin
        if (!rst_n) begin
            hold <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h44) begin
            hold <= wb_dat_i[0];
        end
    end
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ACK_CYC: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("stray ack");
    AST_ACK_BOUND: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:40] wb_ack_o)
        else $error("no ack");
    AST_RST_QUIET: assert property ($rose(rst_n) |-> (term_out == 16'h0000) [*8])
        else $error("terminal on after reset");
    AST_WR_DAT: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0) else $error("wr data");
    AST_CODE_RD: assert property (rd && wb_adr_i <= 8'h3C |-> wb_dat_o[31:8] == 24'h0)
        else $error("code upper bits");
    AST_UNMAPPED: assert property (rd && wb_adr_i > 8'h44 |-> wb_dat_o == 32'h0)
        else $error("unmapped read");
    AST_STAT_RD: assert property (rd && wb_adr_i == 8'h40 |-> wb_dat_o[31:18] == 14'h0)
        else $error("status upper bits");
    AST_HOLD_OFF: assert property (hold && $past(hold, 2) |-> term_out == 16'h0)
        else $error("terminal on in hold");
    cover property (rd && wb_adr_i == 8'h40);
    cover property (hold && $past(hold, 2));
    cover property (wb_ack_o && wb_we_i && wb_adr_i <= 8'h3C);
endmodule

// file: terminal_reader.sv
// partner: outside equipment sampling the terminals
// assumes plain levels read on the system clock
`timescale 1ns/100ps
module terminal_reader (
    input wire clock,
    input wire [15:0] term_out,
    output reg [15:0] seen
);
    // one input register, as a synchronous receiver would have
    always @(posedge clock) begin
        seen <= term_out;
    end
endmodule

// file: test_output_signal_selector.sv
// bench: wishbone tasks, walk of the source table, pulses, toggle, hold-off
// assumes the selector, its checker and the terminal reader
`timescale 1ns/100ps
module test_output_signal_selector;
    localparam [223:0] cd = {8'hA7, 8'hA6, 8'hA5, 8'hA4, 8'hA3, 8'hA2, 8'hA1, 8'hA0, 8'h9C,
        8'h9A, 8'h99, 8'h97, 8'h96, 8'h95, 8'h91, 8'h90, 8'h8F, 8'h8E, 8'h8D, 8'h8C, 8'h8A,
        8'h88, 8'h87, 8'h86, 8'h84, 8'h83, 8'h82, 8'h81};
    localparam [63:0] dc = {8'h00, 8'h80, 8'h85, 8'h89, 8'h8B, 8'h9E, 8'hA8, 8'hFF};
    reg clock, rst_n, cyc, stb, we;
    reg [7:0] adr, c;
    reg [3:0] sel, t;
    reg [31:0] dat, q;
    reg [29:0] lv;
    reg [127:0] ist;
    reg [2:0] pl;
    wire [31:0] dout;
    wire ack;
    wire [15:0] term, seen;
    integer n_fail, n_compared, i, s, k;
    output_signal_selector dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
        .wb_ack_o(ack), .input_state(ist), .alarm(lv[0]), .system_prepared(lv[2]),
        .drive_ready(lv[3]), .motor_moving(lv[4]), .present_a(lv[5]),
        .internal_processing(lv[6]), .positioning_done(lv[7]), .torque_at_limit(lv[8]),
        .speed_reached(lv[9]), .motor_excited(lv[10]), .current_cutback(lv[11]),
        .home_reached(lv[12]), .coords_established(lv[13]), .preset_required(lv[14]),
        .mech_home_set(lv[15]), .factory_home_set(lv[16]), .fwd_soft_limit(lv[17]),
        .rev_soft_limit(lv[18]), .wrap_home_flag(lv[19]), .window_flag(lv[27:20]),
        .cyclic_sync_position_mode(lv[28]), .wrap_enable(lv[29]), .wrap_exceeded(pl[2]),
        .rev_pulse(pl[0]), .step_angle_pulse(pl[1]), .term_out(term));
    terminal_reader reader (.clock(clock), .term_out(term), .seen(seen));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task close_out;
        begin
            $display("compared %0d failed %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // master waits for ack with no assumed latency; the limit only catches a hang
    task wb(input [7:0] a, input w, input [31:0] d, output [31:0] r);
        integer n;
        begin
            n = 0;
            @(posedge clock);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            @(posedge clock);
            while (ack !== 1'b1 && n < 200) begin
                @(posedge clock);
                n = n + 1;
            end
            r = dout;
            cyc <= 1'b0;
            stb <= 1'b0;
            chk(n < 200, 32'h1);
        end
    endtask
    task settle;
        repeat (24) @(posedge clock);
    endtask
    task pulse(input [2:0] m);
        begin
            @(posedge clock);
            pl <= m;
            @(posedge clock);
            pl <= 3'h0;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_fail = n_fail + 1;
        close_out;
    end
    initial begin
        n_fail = 0;
        n_compared = 0;
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        dat = 32'h0;
        lv = 30'h0;
        ist = 128'h0;
        pl = 3'h0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        q = 32'h0;
        for (k = 0; k < 50 && q[16] !== 1'b1; k = k + 1) begin
            wb(8'h40, 1'b0, 32'h0, q);
        end
        chk(q, 32'h00010000);
        $display("test reset done");
        for (i = 0; i < 28; i = i + 1) begin
            c = cd[8*i +: 8];
            t = i[3:0];
            s = (i == 1) ? 0 : i;
            wb({2'b00, t, 2'b00}, 1'b1, {24'h0, c}, q);
            lv <= 30'h0;
            settle;
            chk({31'h0, seen[t]}, {31'h0, c == 8'h82});
            lv <= (30'h1 << s) | 30'h20000000;
            settle;
            chk({31'h0, seen[t]}, {31'h0, c != 8'h82});
            if (c == 8'h8A || c == 8'h8D || c == 8'h9C) begin
                lv <= (c == 8'h9C) ? (30'h1 << s) : ((30'h1 << s) | 30'h10000000);
                settle;
                chk({31'h0, seen[t]}, 32'h0);
            end
        end
        wb(8'h3C, 1'b0, 32'h0, q);
        chk(q, 32'h00000096);
        $display("test sources done");
        lv <= 30'h3FFFFFFF;
        ist <= {128{1'b1}};
        for (i = 0; i < 8; i = i + 1) begin
            wb(8'h00, 1'b1, {24'h0, dc[8*i +: 8]}, q);
            settle;
            chk({31'h0, seen[0]}, 32'h0);
        end
        for (i = 1; i < 128; i = i + 126) begin
            wb(8'h04, 1'b1, i, q);
            ist <= 128'h1 << i;
            settle;
            chk({31'h0, seen[1]}, 32'h1);
            ist <= ~(128'h1 << i);
            settle;
            chk({31'h0, seen[1]}, 32'h0);
        end
        $display("test codes done");
        for (i = 0; i < 2; i = i + 1) begin
            wb(8'h08, 1'b1, (i == 0) ? 32'h9B : 32'h9D, q);
            settle;
            pulse(3'h1 << i);
            s = 0;
            repeat (60) begin
                @(posedge clock);
                s = s + seen[2];
            end
            chk(s == 16 || s == 32, 32'h1);
            chk({31'h0, seen[2]}, 32'h0);
        end
        wb(8'h08, 1'b1, 32'h98, q);
        for (i = 1; i < 3; i = i + 1) begin
            pulse(3'h4);
            settle;
            wb(8'h40, 1'b0, 32'h0, q);
            chk({31'h0, seen[2]}, i % 2);
            chk({31'h0, q[17]}, i % 2);
        end
        $display("test events done");
        wb(8'h44, 1'b1, 32'h1, q);
        settle;
        chk({16'h0, seen}, 32'h0);
        wb(8'h44, 1'b0, 32'h0, q);
        chk(q, 32'h1);
        wb(8'h44, 1'b1, 32'h0, q);
        wb(8'h80, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        sel <= 4'h0;
        wb(8'h00, 1'b1, 32'h81, q);
        sel <= 4'hF;
        wb(8'h00, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        $display("test control done");
        close_out;
    end
endmodule
bind output_signal_selector output_selector_checker chk_i (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .term_out(term_out));
